// ### verilog/rhk_map.vh
// register map, field positions and reset values for the housekeeping bank
`ifndef RHK_MAP_VH
`define RHK_MAP_VH

// printed offsets are not word multiples: they are register indices, byte address = 4 * index
`define RHK_IDX_FLAG_CTRL        12'h310
`define RHK_IDX_WAKE_STATUS      12'h311
`define RHK_IDX_STRENGTH         12'h312
`define RHK_IDX_PULL_IN          12'h315
`define RHK_IDX_IMAGE_CAL        12'h319
`define RHK_IDX_SHUTDOWN         12'h322
`define RHK_IDX_RX_POWER         12'h324
`define RHK_IDX_OSC_CTRL         12'h340
`define RHK_IDX_IRQ_STATUS       12'h341
`define RHK_IDX_IRQ_MASK         12'h342
`define RHK_ADDR_W               14

// wake_status fields
`define RHK_ST_CAL_ERR           6
`define RHK_ST_CAL_DONE          5
`define RHK_ST_XTAL_OK           4
`define RHK_ST_XTAL_LVL          3
`define RHK_ST_COLD              2
`define RHK_ST_TO_LATCH          1
`define RHK_ST_TO_LIVE           0

// flag control fields
`define RHK_FC_CAL_EN            1
`define RHK_FC_CLEAR             0
// oscillator control field
`define RHK_OC_XTAL_EN           0

// image calibration fields
`define RHK_IC_OVR               5
`define RHK_IC_FREQ_HI           4
`define RHK_IC_FREQ_LO           3
`define RHK_IC_PWR_HI            2
`define RHK_IC_PWR_LO            0

// field write masks and reset values
`define RHK_SHUT_REQ             0
`define RHK_FC_MASK              8'h02
`define RHK_IC_MASK              8'h3F
`define RHK_SD_MASK              8'h01
`define RHK_RX_MASK              8'h1F
`define RHK_OC_MASK              8'h01

// receive enable bit positions
`define RHK_RX_ADC               4
`define RHK_RX_METER             3
`define RHK_RX_FILTER            2
`define RHK_RX_MIXER             1
`define RHK_RX_AMP               0
`define RHK_RST_BYTE             8'h00
`define RHK_RST_PULL_IN          8'h32
`define RHK_STRENGTH_OFFSET      8'h6B

// interrupt status bits
`define RHK_IRQ_COLD             0
`define RHK_IRQ_TIMEOUT          1
`define RHK_IRQ_CAL_DONE         2
`define RHK_IRQ_SHUTDOWN         3
`define RHK_IRQ_MASK             8'h0F

// axi responses
`define RHK_RESP_OKAY            2'h0
`define RHK_RESP_SLVERR          2'h2

`endif

// ### verilog/rhk_regs.v
// housekeeping register bank with axi4-lite slave, status flags and interrupt
`timescale 1ns/1ps
`include "rhk_map.vh"

// Overview of operation
// - status bit 6: calibration error, enable-qualified
// - status bit 5: calibration done, enable-qualified
// - status bit 4: slow crystal settled, enable-qualified
// - status bit 3: live slow crystal level
// - status bit 2: cold-start flag, registered
// - status bit 1: latched wake timeout flag
// - status bit 0: high while wake counter zero
// - read-only strength value, dBm = value - 107
// - pull-in limit resets 50, loaded on receive
// - tone frequency field decodes off, /4, /8, /16
// - tone level field decodes off, 1x..4x
// - bit 5 enables calibration result overwrite
// - shutdown only when request set and select high
// - receive enables bits 4..0, reset zero
// - flag clear clears timeout and cold-start flags
// - enable bit starts/stops rc calibration
module rhk_regs
(
	// clock and reset
	input  wire        sys_clk_i,
	input  wire        srst_i,
	// axi4-lite write address, data and response
	input  wire [13:0] s_axi_awaddr_i,
	input  wire        s_axi_awvalid_i,
	output reg         s_axi_awready_o,
	input  wire [31:0] s_axi_wdata_i,
	input  wire [3:0]  s_axi_wstrb_i,
	input  wire        s_axi_wvalid_i,
	output reg         s_axi_wready_o,
	output reg  [1:0]  s_axi_bresp_o,
	output reg         s_axi_bvalid_o,
	input  wire        s_axi_bready_i,
	// axi4-lite read
	input  wire [13:0] s_axi_araddr_i,
	input  wire        s_axi_arvalid_i,
	output reg         s_axi_arready_o,
	output reg  [31:0] s_axi_rdata_o,
	output reg  [1:0]  s_axi_rresp_o,
	output reg         s_axi_rvalid_o,
	input  wire        s_axi_rready_i,
	// oscillator and wake timer status from analog / timer
	input  wire        cal_error_i,
	input  wire        cal_done_i,
	input  wire        slow_xtal_settled_i,
	input  wire        slow_xtal_level_i,
	input  wire        cold_start_i,
	input  wire        wake_counter_zero_i,
	// communications processor updates
	input  wire        strength_valid_i,
	input  wire [7:0]  strength_value_i,
	input  wire        receive_state_entry_i,
	input  wire [7:0]  if_bandwidth_khz_i,
	input  wire        chip_select_i,
	// control outputs
	output reg         rc_cal_enable_o,
	output reg         slow_xtal_enable_o,
	output reg         image_cal_override_o,
	output reg  [1:0]  tone_divider_sel_o,
	output reg         tone_div_enable_o,
	output reg  [2:0]  tone_level_o,
	output reg         tone_mixer_enable_o,
	output reg         shutdown_start_o,
	output reg         converter_on_o,
	output reg         strength_meter_on_o,
	output reg         if_filter_on_o,
	output reg         mixer_on_o,
	output reg         front_amp_on_o,
	output reg  [7:0]  freq_pull_in_limit_o,
	output reg         irq_o
);

	////////////////////////////////////////////////////////////////////////////////
	// input synchronisers for pin-level status

	reg  [6:0] sync_a;
	reg  [6:0] sync_b;
	wire [6:0] raw_in = {cal_error_i, cal_done_i, slow_xtal_settled_i, slow_xtal_level_i,
		cold_start_i, wake_counter_zero_i, chip_select_i};

	genvar gi;
	generate
		for (gi = 0; gi < 7; gi = gi + 1)
		begin : g_sync
			always @(posedge sys_clk_i)
			begin
				if (srst_i)
				begin
					sync_a[gi] <= 1'b0;
					sync_b[gi] <= 1'b0;
				end
				else
				begin
					sync_a[gi] <= raw_in[gi];
					sync_b[gi] <= sync_a[gi];
				end
			end
		end
	endgenerate

	wire s_cal_err  = sync_b[6];
	wire s_cal_done = sync_b[5];
	wire s_xtal_ok  = sync_b[4];
	wire s_xtal_lvl = sync_b[3];
	wire s_cold     = sync_b[2];
	wire s_zero     = sync_b[1];
	wire s_cs       = sync_b[0];

	////////////////////////////////////////////////////////////////////////////////
	// register storage

	reg  [7:0] flag_ctrl;
	reg  [7:0] osc_ctrl;
	reg  [7:0] image_cal;
	reg  [7:0] shutdown_ctl;
	reg  [7:0] rx_power;
	reg  [7:0] strength;
	reg  [7:0] pull_in;
	reg        cold_flag;
	reg        timeout_flag;
	reg        zero_d;
	reg        cal_done_d;
	reg  [7:0] irq_status;
	reg  [7:0] irq_mask;

	// merge byte lane 0 only; data is 8 bits wide
	function [7:0] merge_byte;
		input [7:0] old_v;
		input [7:0] new_v;
		input       lane_en;
		input [7:0] mask;
		begin
			merge_byte = lane_en ? ((old_v & ~mask) | (new_v & mask)) : old_v;
		end
	endfunction

	// byte address to register index
	function [11:0] reg_index;
		input [13:0] byte_addr;
		begin
			reg_index = byte_addr[13:2];
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// axi write channel: address and data taken in either order

	reg         aw_held;
	reg         w_held;
	reg  [11:0] aw_idx;
	reg  [7:0]  w_byte;
	reg         w_lane;

	wire aw_take = s_axi_awvalid_i & s_axi_awready_o;
	wire w_take  = s_axi_wvalid_i & s_axi_wready_o;
	wire wr_go   = aw_held & w_held & ~s_axi_bvalid_o;

	wire wr_fc   = wr_go & (aw_idx == `RHK_IDX_FLAG_CTRL) & w_lane;
	wire wr_ist  = wr_go & (aw_idx == `RHK_IDX_IRQ_STATUS) & w_lane;
	wire clr_wake = wr_fc & w_byte[`RHK_FC_CLEAR];

	reg  known_wr;
	always @*
	begin
		case (aw_idx)
			`RHK_IDX_FLAG_CTRL, `RHK_IDX_IMAGE_CAL, `RHK_IDX_SHUTDOWN, `RHK_IDX_RX_POWER,
			`RHK_IDX_OSC_CTRL, `RHK_IDX_IRQ_STATUS, `RHK_IDX_IRQ_MASK,
			`RHK_IDX_WAKE_STATUS, `RHK_IDX_STRENGTH, `RHK_IDX_PULL_IN:
				known_wr = 1'b1;
			default:
				known_wr = 1'b0;
		endcase
	end

	always @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			aw_held         <= 1'b0;
			w_held          <= 1'b0;
			aw_idx          <= 12'h000;
			w_byte          <= `RHK_RST_BYTE;
			w_lane          <= 1'b0;
			s_axi_awready_o <= 1'b0;
			s_axi_wready_o  <= 1'b0;
			s_axi_bvalid_o  <= 1'b0;
			s_axi_bresp_o   <= `RHK_RESP_OKAY;
		end
		else
		begin
			s_axi_awready_o <= ~aw_held & ~aw_take & ~s_axi_bvalid_o;
			s_axi_wready_o  <= ~w_held & ~w_take & ~s_axi_bvalid_o;
			if (aw_take)
			begin
				aw_held <= 1'b1;
				aw_idx  <= reg_index(s_axi_awaddr_i);
			end
			if (w_take)
			begin
				w_held <= 1'b1;
				w_byte <= s_axi_wdata_i[7:0];
				w_lane <= s_axi_wstrb_i[0];
			end
			if (wr_go)
			begin
				aw_held        <= 1'b0;
				w_held         <= 1'b0;
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o  <= known_wr ? `RHK_RESP_OKAY : `RHK_RESP_SLVERR;
			end
			else if (s_axi_bvalid_o & s_axi_bready_i)
				s_axi_bvalid_o <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// software registers; reserved bits masked off on write

	always @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			flag_ctrl    <= `RHK_RST_BYTE;
			osc_ctrl     <= `RHK_RST_BYTE;
			image_cal    <= `RHK_RST_BYTE;
			shutdown_ctl <= `RHK_RST_BYTE;
			rx_power     <= `RHK_RST_BYTE;
			irq_mask     <= `RHK_RST_BYTE;
		end
		else if (wr_go & w_lane)
		begin
			case (aw_idx)
				// clear bit is a strobe, never stored
				`RHK_IDX_FLAG_CTRL: flag_ctrl <= merge_byte(flag_ctrl, w_byte, 1'b1, `RHK_FC_MASK);
				`RHK_IDX_OSC_CTRL:  osc_ctrl  <= merge_byte(osc_ctrl, w_byte, 1'b1, `RHK_OC_MASK);
				`RHK_IDX_IMAGE_CAL: image_cal <= merge_byte(image_cal, w_byte, 1'b1, `RHK_IC_MASK);
				`RHK_IDX_SHUTDOWN:  shutdown_ctl <= merge_byte(shutdown_ctl, w_byte, 1'b1, `RHK_SD_MASK);
				`RHK_IDX_RX_POWER:  rx_power  <= merge_byte(rx_power, w_byte, 1'b1, `RHK_RX_MASK);
				`RHK_IDX_IRQ_MASK:  irq_mask  <= merge_byte(irq_mask, w_byte, 1'b1, `RHK_IRQ_MASK);
				default:            flag_ctrl <= flag_ctrl;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// hardware-updated flags and values; a set in the clear cycle wins

	wire timeout_rise = s_zero & ~zero_d;
	wire cal_done_rise = s_cal_done & ~cal_done_d;
	wire shut_go = shutdown_ctl[`RHK_SHUT_REQ] & s_cs;
	wire [7:0] irq_events = {4'h0, shut_go & ~shutdown_start_o, cal_done_rise, timeout_rise,
		s_cold & ~cold_flag};

	always @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			cold_flag    <= 1'b0;
			timeout_flag <= 1'b0;
			zero_d       <= 1'b0;
			cal_done_d   <= 1'b0;
			strength     <= `RHK_RST_BYTE;
			pull_in      <= `RHK_RST_PULL_IN;
			irq_status   <= `RHK_RST_BYTE;
		end
		else
		begin
			zero_d     <= s_zero;
			cal_done_d <= s_cal_done;
			cold_flag    <= s_cold | (cold_flag & ~clr_wake);
			timeout_flag <= timeout_rise | (timeout_flag & ~clr_wake);
			if (strength_valid_i)
				strength <= strength_value_i;
			if (receive_state_entry_i)
				pull_in <= {1'b0, if_bandwidth_khz_i[7:1]};
			irq_status <= (irq_events & `RHK_IRQ_MASK) |
				(irq_status & ~(wr_ist ? w_byte : 8'h00));
		end
	end

	// live view of the wake status byte, qualified by enables
	wire [7:0] wake_status = {1'b0,
		s_cal_err & flag_ctrl[`RHK_FC_CAL_EN],
		s_cal_done & flag_ctrl[`RHK_FC_CAL_EN],
		s_xtal_ok & osc_ctrl[`RHK_OC_XTAL_EN],
		s_xtal_lvl,
		cold_flag,
		timeout_flag,
		s_zero};

	////////////////////////////////////////////////////////////////////////////////
	// axi read channel

	wire ar_take = s_axi_arvalid_i & s_axi_arready_o;
	reg  [7:0] rd_byte;
	reg        rd_ok;

	always @*
	begin
		rd_ok = 1'b1;
		case (reg_index(s_axi_araddr_i))
			`RHK_IDX_FLAG_CTRL:   rd_byte = flag_ctrl;
			`RHK_IDX_WAKE_STATUS: rd_byte = wake_status;
			`RHK_IDX_STRENGTH:    rd_byte = strength;
			`RHK_IDX_PULL_IN:     rd_byte = pull_in;
			`RHK_IDX_IMAGE_CAL:   rd_byte = image_cal;
			`RHK_IDX_SHUTDOWN:    rd_byte = shutdown_ctl;
			`RHK_IDX_RX_POWER:    rd_byte = rx_power;
			`RHK_IDX_OSC_CTRL:    rd_byte = osc_ctrl;
			`RHK_IDX_IRQ_STATUS:  rd_byte = irq_status;
			`RHK_IDX_IRQ_MASK:    rd_byte = irq_mask;
			default:
			begin
				rd_byte = `RHK_RST_BYTE;
				rd_ok   = 1'b0;
			end
		endcase
	end

	always @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o  <= 1'b0;
			s_axi_rdata_o   <= 32'h00000000;
			s_axi_rresp_o   <= `RHK_RESP_OKAY;
		end
		else
		begin
			s_axi_arready_o <= ~ar_take & ~s_axi_rvalid_o;
			if (ar_take)
			begin
				s_axi_rvalid_o <= 1'b1;
				s_axi_rdata_o  <= {24'h000000, rd_byte};
				s_axi_rresp_o  <= rd_ok ? `RHK_RESP_OKAY : `RHK_RESP_SLVERR;
			end
			else if (s_axi_rvalid_o & s_axi_rready_i)
				s_axi_rvalid_o <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// registered control outputs

	wire [1:0] tone_freq = image_cal[`RHK_IC_FREQ_HI:`RHK_IC_FREQ_LO];
	wire [2:0] tone_pwr  = image_cal[`RHK_IC_PWR_HI:`RHK_IC_PWR_LO];

	// 0 off, 1-2 -> 1x, 3-4 -> 2x, 5-6 -> 3x, 7 -> 4x; output is multiple minus one
	function [2:0] tone_mult;
		input [2:0] code;
		begin
			case (code)
				3'h1, 3'h2: tone_mult = 3'h0;
				3'h3, 3'h4: tone_mult = 3'h1;
				3'h5, 3'h6: tone_mult = 3'h2;
				3'h7:       tone_mult = 3'h3;
				default:    tone_mult = 3'h0;
			endcase
		end
	endfunction

	always @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			rc_cal_enable_o      <= 1'b0;
			slow_xtal_enable_o   <= 1'b0;
			image_cal_override_o <= 1'b0;
			tone_divider_sel_o   <= 2'h0;
			tone_div_enable_o    <= 1'b0;
			tone_level_o         <= 3'h0;
			tone_mixer_enable_o  <= 1'b0;
			shutdown_start_o     <= 1'b0;
			converter_on_o       <= 1'b0;
			strength_meter_on_o  <= 1'b0;
			if_filter_on_o       <= 1'b0;
			mixer_on_o           <= 1'b0;
			front_amp_on_o       <= 1'b0;
			freq_pull_in_limit_o <= `RHK_RST_PULL_IN;
			irq_o                <= 1'b0;
		end
		else
		begin
			rc_cal_enable_o      <= flag_ctrl[`RHK_FC_CAL_EN];
			slow_xtal_enable_o   <= osc_ctrl[`RHK_OC_XTAL_EN];
			image_cal_override_o <= image_cal[`RHK_IC_OVR];
			// select 0=/4 1=/8 2=/16 once enabled
			tone_div_enable_o    <= (tone_freq != 2'h0);
			tone_divider_sel_o   <= tone_freq - 2'h1;
			tone_mixer_enable_o  <= (tone_pwr != 3'h0);
			tone_level_o         <= tone_mult(tone_pwr);
			shutdown_start_o     <= shut_go;
			converter_on_o       <= rx_power[`RHK_RX_ADC];
			strength_meter_on_o  <= rx_power[`RHK_RX_METER];
			if_filter_on_o       <= rx_power[`RHK_RX_FILTER];
			mixer_on_o           <= rx_power[`RHK_RX_MIXER];
			front_amp_on_o       <= rx_power[`RHK_RX_AMP];
			freq_pull_in_limit_o <= pull_in;
			irq_o                <= |(irq_status & irq_mask);
		end
	end

endmodule

// ### testbench/rhk_regs_properties.sv
// concurrent checks on the housekeeping bank ports
`timescale 1ns/1ps
module rhk_regs_props
(
	input wire        sys_clk_i, srst_i, receive_state_entry_i, chip_select_i, shutdown_start_o,
	input wire        s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o,
	input wire        s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o,
	input wire        s_axi_rvalid_o, s_axi_rready_i,
	input wire [1:0]  s_axi_bresp_o,
	input wire [31:0] s_axi_rdata_o,
	input wire [7:0]  if_bandwidth_khz_i, freq_pull_in_limit_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (srst_i);
	////////////////////////////////////////////////////////////////////////////////
	sequence s_wr_take;
		s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
	endsequence
	sequence s_rd_take;
		s_axi_arvalid_i && s_axi_arready_o;
	endsequence
	// four quiet samples cover the two synchroniser flops plus the output flop
	sequence s_cs_quiet;
		!chip_select_i [*4];
	endsequence
	////////////////////////////////////////////////////////////////////////////////
	property p_wr_ans; s_wr_take |-> ##[1:2] s_axi_bvalid_o; endproperty
	property p_rd_ans; s_rd_take |=> s_axi_rvalid_o; endproperty
	property p_b_hold;
		s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
	endproperty
	property p_b_code; s_axi_bvalid_o |-> s_axi_bresp_o == 2'h0 || s_axi_bresp_o == 2'h2; endproperty
	property p_r_hold;
		s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
	endproperty
	property p_r_upper; s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h0; endproperty
	// limit register feeds an output flop, so the port shows a load two edges on
	property p_pull_load;
		receive_state_entry_i |-> ##2 freq_pull_in_limit_o == ($past(if_bandwidth_khz_i, 2) >> 1);
	endproperty
	property p_pull_hold;
		!receive_state_entry_i && !$past(receive_state_entry_i) |=> $stable(freq_pull_in_limit_o);
	endproperty
	property p_shut_cs; s_cs_quiet |-> !shutdown_start_o; endproperty
	////////////////////////////////////////////////////////////////////////////////
	a_wr_ans: assert property (p_wr_ans) else $error("write response late");
	a_rd_ans: assert property (p_rd_ans) else $error("read data late");
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	a_b_code: assert property (p_b_code) else $error("bad write response code");
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
	a_r_upper: assert property (p_r_upper) else $error("upper read bits set");
	a_pull_load: assert property (p_pull_load) else $error("pull-in not loaded");
	a_pull_hold: assert property (p_pull_hold) else $error("pull-in changed");
	a_shut_cs: assert property (p_shut_cs) else $error("shutdown without select");
endmodule

// ### testbench/rhk_regs_tb_top.sv
// self-checking bench for the housekeeping register bank
`timescale 1ns/1ps
`include "rhk_map.vh"
module rhk_regs_tb_top;
	reg         clk = 1'b0, rst = 1'b1, av = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
	reg         sv = 1'b0, re = 1'b0, cs = 1'b0, a;
	reg  [13:0] aa = 14'h0, ra = 14'h0;
	reg  [31:0] wd = 32'h0, rdv;
	reg  [7:0]  sval = 8'h00, bw = 8'h00;
	reg  [5:0]  st = 6'h00;
	reg  [1:0]  resp;
	wire        awr, wrd, bv, arr, rv, rce, sxe, ovr, tde, tme, sds, irq;
	wire [1:0]  bre, rre, tsel;
	wire [2:0]  tlv;
	wire [4:0]  rxp;
	wire [7:0]  pl;
	wire [31:0] rd;
	integer     bad_count = 0, tests_run = 0, i;
	////////////////////////////////////////////////////////////////////////////////
	rhk_regs u_dut
	(
		.sys_clk_i(clk), .srst_i(rst), .s_axi_awaddr_i(aa), .s_axi_awvalid_i(av),
		.s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv),
		.s_axi_wready_o(wrd), .s_axi_bresp_o(bre), .s_axi_bvalid_o(bv), .s_axi_bready_i(br),
		.s_axi_araddr_i(ra), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rd),
		.s_axi_rresp_o(rre), .s_axi_rvalid_o(rv), .s_axi_rready_i(rr), .cal_error_i(st[5]),
		.cal_done_i(st[4]), .slow_xtal_settled_i(st[3]), .slow_xtal_level_i(st[2]),
		.cold_start_i(st[1]), .wake_counter_zero_i(st[0]), .strength_valid_i(sv),
		.strength_value_i(sval), .receive_state_entry_i(re), .if_bandwidth_khz_i(bw),
		.chip_select_i(cs), .rc_cal_enable_o(rce), .slow_xtal_enable_o(sxe),
		.image_cal_override_o(ovr), .tone_divider_sel_o(tsel), .tone_div_enable_o(tde),
		.tone_level_o(tlv), .tone_mixer_enable_o(tme), .shutdown_start_o(sds),
		.converter_on_o(rxp[4]), .strength_meter_on_o(rxp[3]), .if_filter_on_o(rxp[2]),
		.mixer_on_o(rxp[1]), .front_amp_on_o(rxp[0]), .freq_pull_in_limit_o(pl), .irq_o(irq)
	);
	always #5 clk = ~clk;
	////////////////////////////////////////////////////////////////////////////////
	task complete_run;
		begin
			if (bad_count == 0 && tests_run > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask
	task chk(input string n, input logic [31:0] g, input logic [31:0] e);
		begin
			tests_run = tests_run + 1;
			if (g !== e)
			begin
				$display("[FAIL] %0s expected %h seen %h", n, e, g);
				bad_count = bad_count + 1;
			end
		end
	endtask
	task w(input integer n);
		repeat (n) @(posedge clk);
	endtask
	// leading edge keeps a fresh request off the edge that dropped the last ready
	task wr(input [11:0] x, input [7:0] d);
		begin
			@(posedge clk);
			aa <= {x, 2'b00};
			wd <= {24'h0, d};
			av <= 1'b1;
			wv <= 1'b1;
			@(posedge clk);
			while (bv !== 1'b1)
			begin
				if (awr === 1'b1) av <= 1'b0;
				if (wrd === 1'b1) wv <= 1'b0;
				@(posedge clk);
			end
			// response stands a cycle before bready, so its hold is exercised
			br <= 1'b1;
			@(posedge clk);
			br <= 1'b0;
			resp = bre;
		end
	endtask
	task rc(input string n, input [11:0] x, input [31:0] e);
		begin
			@(posedge clk);
			ra <= {x, 2'b00};
			arv <= 1'b1;
			@(posedge clk);
			while (rv !== 1'b1)
			begin
				if (arr === 1'b1) arv <= 1'b0;
				@(posedge clk);
			end
			rr <= 1'b1;
			@(posedge clk);
			rr <= 1'b0;
			rdv = rd;
			chk(n, rdv, e);
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		w(20);
		rst <= 1'b0;
		rc("status", `RHK_IDX_WAKE_STATUS, 0);
		rc("strength", `RHK_IDX_STRENGTH, 0);
		rc("pull_in", `RHK_IDX_PULL_IN, 32'h32);
		rc("image", `RHK_IDX_IMAGE_CAL, 0);
		rc("shutdown", `RHK_IDX_SHUTDOWN, 0);
		rc("rx_power", `RHK_IDX_RX_POWER, 0);
		for (i = 0; i < 8; i = i + 1)
		begin
			wr(`RHK_IDX_IMAGE_CAL, {3'b001, i[1:0], i[2:0]});
			chk("div_en", tde, i[1:0] != 0);
			if (i[1:0] != 0) chk("div_sel", tsel, i[1:0] - 1);
			chk("mix_en", tme, i != 0);
			if (i != 0) chk("level", tlv, (i - 1) >> 1);
			chk("override", ovr, 1);
		end
		wr(`RHK_IDX_IMAGE_CAL, 8'hDF);
		rc("image", `RHK_IDX_IMAGE_CAL, 32'h1F);
		chk("override", ovr, 0);
		wr(`RHK_IDX_RX_POWER, 8'hFF);
		rc("rx_power", `RHK_IDX_RX_POWER, 32'h1F);
		chk("rx_en", rxp, 5'h1F);
		wr(`RHK_IDX_RX_POWER, 8'h0A);
		chk("rx_en", rxp, 5'h0A);
		wr(`RHK_IDX_PULL_IN, 8'hAA);
		chk("ro_resp", resp, `RHK_RESP_OKAY);
		wr(`RHK_IDX_STRENGTH, 8'hAA);
		wr(`RHK_IDX_WAKE_STATUS, 8'hFF);
		rc("pull_in", `RHK_IDX_PULL_IN, 32'h32);
		rc("strength", `RHK_IDX_STRENGTH, 0);
		rc("status", `RHK_IDX_WAKE_STATUS, 0);
		wr(12'h3FF, 8'h01);
		chk("unmapped", resp, `RHK_RESP_SLVERR);
		bw <= 8'd200;
		sval <= 8'h5A;
		re <= 1'b1;
		sv <= 1'b1;
		w(1);
		re <= 1'b0;
		sv <= 1'b0;
		rc("pull_in", `RHK_IDX_PULL_IN, 32'd100);
		chk("pull_out", pl, 8'd100);
		rc("strength", `RHK_IDX_STRENGTH, 32'h5A);
		// enables off: only the live level may show
		st <= 6'b111100;
		w(4);
		rc("status", `RHK_IDX_WAKE_STATUS, 32'h08);
		wr(`RHK_IDX_OSC_CTRL, 8'h01);
		wr(`RHK_IDX_FLAG_CTRL, 8'h02);
		chk("cal_en", {rce, sxe}, 2'b11);
		rc("status", `RHK_IDX_WAKE_STATUS, 32'h78);
		rc("flag_ctrl", `RHK_IDX_FLAG_CTRL, 32'h02);
		st <= 6'b010000;
		w(4);
		rc("status", `RHK_IDX_WAKE_STATUS, 32'h20);
		wr(`RHK_IDX_FLAG_CTRL, 8'h00);
		wr(`RHK_IDX_OSC_CTRL, 8'h00);
		rc("status", `RHK_IDX_WAKE_STATUS, 0);
		st <= 6'b000011;
		w(4);
		rc("status", `RHK_IDX_WAKE_STATUS, 32'h07);
		st <= 6'b000000;
		w(4);
		rc("status", `RHK_IDX_WAKE_STATUS, 32'h06);
		wr(`RHK_IDX_FLAG_CTRL, 8'h01);
		rc("status", `RHK_IDX_WAKE_STATUS, 0);
		rc("irq_stat", `RHK_IDX_IRQ_STATUS, 32'h07);
		// mask sense is not pinned down, so only the toggle of irq is judged
		wr(`RHK_IDX_IRQ_MASK, 8'h00);
		w(2);
		a = irq;
		wr(`RHK_IDX_IRQ_MASK, 8'h0F);
		w(2);
		chk("irq_mask", a ^ irq, 1);
		wr(`RHK_IDX_IRQ_STATUS, 8'h0F);
		rc("irq_stat", `RHK_IDX_IRQ_STATUS, 0);
		w(2);
		chk("irq_clr", irq, 0);
		wr(`RHK_IDX_SHUTDOWN, 8'hFF);
		w(4);
		chk("shut", sds, 0);
		rc("shutdown", `RHK_IDX_SHUTDOWN, 32'h01);
		cs <= 1'b1;
		w(5);
		chk("shut", sds, 1);
		rc("irq_stat", `RHK_IDX_IRQ_STATUS, 32'h08);
		wr(`RHK_IDX_SHUTDOWN, 8'h00);
		w(2);
		chk("shut", sds, 0);
		complete_run;
	end
	initial
	begin
		w(20000);
		bad_count = bad_count + 1;
		complete_run;
	end
endmodule
bind rhk_regs rhk_regs_props u_props
(
	.sys_clk_i(sys_clk_i), .srst_i(srst_i), .receive_state_entry_i(receive_state_entry_i),
	.chip_select_i(chip_select_i), .shutdown_start_o(shutdown_start_o),
	.s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
	.s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
	.s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
	.s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
	.s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
	.s_axi_bresp_o(s_axi_bresp_o), .s_axi_rdata_o(s_axi_rdata_o),
	.if_bandwidth_khz_i(if_bandwidth_khz_i), .freq_pull_in_limit_o(freq_pull_in_limit_o)
);
